/* include/bfcc_pkg.sv */
// constants and types for the banked flash command controller
//----------------------------------------------------------------------
// Notes on behaviour
// - The array is four independent banks of 64 Kbyte each.
// - Each bank is 32K words of 16 bits, read as byte, aligned or misaligned word.
// - Program and erase accept only aligned whole-word accesses, and reject any others with an error flag.
// - Every erased word reads back as all ones.
// - A programmable divider makes the sequencer tick, which software keeps at 150 to 200 kHz.
// - The sequencer erases one 512-byte sector or a whole bank.
// - All four banks can program or erase at once, each with its own sequencer.
// - Command completion raises an interrupt so software need not poll.
// - Each bank has two protected regions, 0.5-4 Kbyte and 2-16 Kbyte, that block program and erase.
// - The last bank holds protection and security values, loaded into registers after reset.
// - An eight-byte backdoor key in that bank is compared with a written key to unsecure.
//----------------------------------------------------------------------
package bfcc_pkg;
  // array shape and counter widths
  localparam int NB = 4;
  localparam int WORDS = 32768;
  localparam int DIV_W = 10;
  localparam int CNT_W = 16;
  // register byte offsets
  localparam logic [7:0] REG_CLKDIV = 8'h00;
  localparam logic [7:0] REG_PROT = 8'h04;
  localparam logic [7:0] REG_SEC = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_CMD = 8'h14;
  localparam logic [7:0] REG_CDATA = 8'h18;
  localparam logic [7:0] REG_CADDR = 8'h1c;
  localparam logic [7:0] REG_RADDR = 8'h20;
  localparam logic [7:0] REG_RDATA = 8'h24;
  localparam logic [7:0] REG_KEY0 = 8'h28;
  localparam logic [7:0] REG_KEY1 = 8'h2c;
  // reset values and field encodings
  localparam logic [DIV_W-1:0] CLKDIV_RST = 10'h000;
  localparam logic [7:0] SEC_RST = 8'h00;
  localparam logic [1:0] SEC_OPEN = 2'h2;
  localparam int PROT_BITS = 6;
  localparam logic [16:0] BANK_BYTES = 17'h10000;
  localparam logic [16:0] PROT_A_BASE = 17'h00200;
  localparam logic [16:0] PROT_B_BASE = 17'h00800;
  localparam int SECTOR_WORDS = 256;
  // security bank word positions, counted back from its end, 1 being its last word
  localparam int KEY_FROM_END = 8;
  localparam int PROT_FROM_END = 4;
  localparam int SEC_FROM_END = 1;
  // sequencer durations in timing ticks
  localparam logic [CNT_W-1:0] PROG_TICKS = 16'h0008;
  localparam logic [CNT_W-1:0] SECT_TICKS = 16'h0fa0;
  localparam logic [CNT_W-1:0] BULK_TICKS = 16'h9c40;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // commands
  typedef enum logic [1:0]
  {
    OP_NONE = 2'h0,
    OP_PROG = 2'h1,
    OP_SECT = 2'h2,
    OP_BULK = 2'h3
  } bfcc_op_t;
endpackage : bfcc_pkg

/* include/bfcc_seq_if.sv */
// start and completion handshake between controller and one bank sequencer
`timescale 1ns/100ps
interface bfcc_seq_if;
  import bfcc_pkg::*;
  logic start;
  bfcc_op_t op;
  logic busy;
  logic done;
  modport ctl (output start, output op, input busy, input done);
  modport seq (input start, input op, output busy, output done);
endinterface : bfcc_seq_if

/* src/bfcc_clkdiv.sv */
// timing tick divider for the command sequencers
`timescale 1ns/100ps
module bfcc_clkdiv
  import bfcc_pkg::*;
#(
  parameter int DW = DIV_W
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // divider setting, zero stops the tick
  input wire logic [DW-1:0] div,
  // one-cycle tick every div+1 cycles
  output logic tick
);
  logic [DW-1:0] cnt_q;
  logic tick_q;

  // count up to div and wrap with a tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn || div == '0)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (cnt_q >= div);
      cnt_q <= (cnt_q >= div) ? '0 : cnt_q + 1'b1;
    end
  end

  assign tick = tick_q;
endmodule : bfcc_clkdiv

/* src/bfcc_bank_seq.sv */
// per-bank program and erase sequencer
`timescale 1ns/100ps
module bfcc_bank_seq
  import bfcc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // timing tick
  input wire logic tick,
  // handshake to controller
  bfcc_seq_if.seq sif
);
  typedef enum logic [2:0]
  {
    S_IDLE = 3'b001,
    S_RUN = 3'b010,
    S_DONE = 3'b100
  } bfcc_st_t;
  bfcc_st_t st_q;
  logic [CNT_W-1:0] cnt_q;

  // duration of a command in ticks
  function automatic logic [CNT_W-1:0] dur(input bfcc_op_t op);
    case (op)
      OP_PROG: return PROG_TICKS;
      OP_SECT: return SECT_TICKS;
      default: return BULK_TICKS;
    endcase
  endfunction : dur

  // idle, count ticks, then one done cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= S_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (st_q)
        S_IDLE:
        begin
          if (sif.start)
          begin
            st_q <= S_RUN;
            cnt_q <= dur(sif.op);
          end
        end
        S_RUN:
        begin
          if (tick)
          begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q <= 16'h0001)
              st_q <= S_DONE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  assign sif.busy = (st_q != S_IDLE);
  assign sif.done = (st_q == S_DONE);
endmodule : bfcc_bank_seq

/* src/bfcc_top.sv */
// banked flash command controller with axi4-lite register access
`timescale 1ns/100ps
module bfcc_top
  import bfcc_pkg::*;
#(
  parameter int WORDS_P = WORDS
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);
  localparam int IW = $clog2(WORDS_P);
  localparam int BW = 2 + IW + 1;
  localparam int SB = NB - 1;

  //--------------------------------------------------------------------
  // storage and state
  //--------------------------------------------------------------------
  logic [15:0] mem_q [NB][WORDS_P];
  logic [DIV_W-1:0] nvm_timing_clock_divider_q;
  logic [NB*PROT_BITS-1:0] nvm_region_protection_q;
  logic [7:0] nvm_security_setting_q;
  logic [63:0] key_q;
  logic [31:0] key_lo_q;
  logic [2*NB-1:0] stat_q;
  logic [2*NB-1:0] stat_d;
  logic [2*NB-1:0] mask_q;
  logic [15:0] cdata_q;
  logic [15:0] caddr_q;
  logic [BW:0] raddr_q;
  logic load_q;
  logic [15:0] bk_addr_q [NB];
  logic [15:0] bk_data_q [NB];
  bfcc_op_t bk_op_q [NB];
  logic [NB-1:0] start;
  logic [NB-1:0] busy;
  logic [NB-1:0] done;
  logic tick;
  // bus holding registers
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  //--------------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------------
  // byte of the whole array, high byte at the even address
  function automatic logic [7:0] byte_at(input logic [BW-1:0] a);
    logic [15:0] w;
    w = mem_q[a[BW-1:BW-2]][a[IW:1]];
    return a[0] ? w[7:0] : w[15:8];
  endfunction : byte_at

  // offset falls in an enabled protected region
  function automatic logic prot_hit(input logic [PROT_BITS-1:0] p,
                                    input logic [15:0] off);
    logic [16:0] a_sz;
    logic [16:0] b_sz;
    a_sz = PROT_A_BASE << p[2:1];
    b_sz = PROT_B_BASE << p[5:4];
    return (p[0] && ({1'b0, off} >= BANK_BYTES - a_sz)) ||
           (p[3] && ({1'b0, off} < b_sz));
  endfunction : prot_hit

  // apply byte strobes to a register word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge

  //--------------------------------------------------------------------
  // timing divider and bank sequencers
  //--------------------------------------------------------------------
  bfcc_clkdiv #(.DW(DIV_W)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .div(nvm_timing_clock_divider_q),
    .tick(tick)
  );

  // one independent sequencer per bank
  for (genvar b = 0; b < NB; b++)
  begin : g_bank
    bfcc_seq_if sif ();
    assign sif.start = start[b];
    assign sif.op = start[b] ? c_op : bk_op_q[b]; // op at launch
    assign busy[b] = sif.busy;
    assign done[b] = sif.done;
    bfcc_bank_seq u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .sif(sif.seq)
    );
  end

  //--------------------------------------------------------------------
  // write decode and command checks
  //--------------------------------------------------------------------
  wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
  wire wr_map = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q <= REG_KEY1);
  wire wr_cmd = wr_fire && aw_addr_q == REG_CMD;
  wire [1:0] c_bank = w_data_q[1:0];
  wire bfcc_op_t c_op = bfcc_op_t'(w_data_q[3:2]);
  wire [PROT_BITS-1:0] c_prot =
    nvm_region_protection_q[c_bank*PROT_BITS +: PROT_BITS];
  wire c_bad_acc = caddr_q[0] || w_strb_q != 4'hf;
  wire c_bad_prot = (c_op == OP_BULK) ? (c_prot[0] || c_prot[3])
                                      : prot_hit(c_prot, caddr_q);
  wire c_reject = c_op == OP_NONE || busy[c_bank] || c_bad_acc ||
                  c_bad_prot || nvm_timing_clock_divider_q == '0;
  wire [NB-1:0] c_sel = NB'(1) << c_bank;
  assign start = (wr_cmd && !c_reject) ? c_sel : '0;
  wire [NB-1:0] err_set = (wr_cmd && c_reject) ? c_sel : '0;
  wire key_fire = wr_fire && aw_addr_q == REG_KEY1;
  wire key_ok = {w_data_q, key_lo_q} == key_q;
  wire [2*NB-1:0] stat_clr = (wr_fire && aw_addr_q == REG_STAT) ?
                             (w_data_q[2*NB-1:0] & {2*NB{w_strb_q[0]}}) : '0;

  // sticky flags, a new event wins over a same-cycle clear
  always_comb
  begin
    stat_d = (stat_q & ~stat_clr) | {err_set, done};
  end

  //--------------------------------------------------------------------
  // axi write channels
  //--------------------------------------------------------------------
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // hold address and data until both are in, then answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------------
  // control registers
  //--------------------------------------------------------------------
  // software-written registers, security load after reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nvm_timing_clock_divider_q <= CLKDIV_RST;
      nvm_region_protection_q <= '0;
      nvm_security_setting_q <= SEC_RST;
      key_q <= 64'h0000000000000000;
      key_lo_q <= 32'h00000000;
      stat_q <= '0;
      mask_q <= '0;
      cdata_q <= 16'h0000;
      caddr_q <= 16'h0000;
      raddr_q <= '0;
      load_q <= 1'b1;
    end
    else
    begin
      stat_q <= stat_d;
      if (load_q)
      begin
        load_q <= 1'b0;
        key_q <= {mem_q[SB][IW'(WORDS_P - KEY_FROM_END)],
                  mem_q[SB][IW'(WORDS_P - KEY_FROM_END + 1)],
                  mem_q[SB][IW'(WORDS_P - KEY_FROM_END + 2)],
                  mem_q[SB][IW'(WORDS_P - KEY_FROM_END + 3)]};
        nvm_region_protection_q <=
          {mem_q[SB][IW'(WORDS_P - PROT_FROM_END + 1)][7:0],
           mem_q[SB][IW'(WORDS_P - PROT_FROM_END)]};
        nvm_security_setting_q <=
          mem_q[SB][IW'(WORDS_P - SEC_FROM_END)][7:0];
      end
      else if (key_fire && key_ok)
        nvm_security_setting_q[1:0] <= SEC_OPEN;
      if (wr_fire)
      begin
        case (aw_addr_q)
          REG_CLKDIV: nvm_timing_clock_divider_q <= DIV_W'(merge(
            32'(nvm_timing_clock_divider_q), w_data_q, w_strb_q));
          REG_PROT: nvm_region_protection_q <= (NB*PROT_BITS)'(merge(
            32'(nvm_region_protection_q), w_data_q, w_strb_q));
          REG_MASK: mask_q <= (2*NB)'(merge(32'(mask_q), w_data_q,
                                            w_strb_q));
          REG_CDATA: cdata_q <= 16'(merge(32'(cdata_q), w_data_q,
                                          w_strb_q));
          REG_CADDR: caddr_q <= 16'(merge(32'(caddr_q), w_data_q,
                                          w_strb_q));
          REG_RADDR: raddr_q <= (BW+1)'(merge(32'(raddr_q), w_data_q,
                                              w_strb_q));
          REG_KEY0: key_lo_q <= merge(key_lo_q, w_data_q, w_strb_q);
          default: ;
        endcase
      end
    end
  end

  // latch each bank's command at launch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int b = 0; b < NB; b++)
      begin
        bk_addr_q[b] <= 16'h0000;
        bk_data_q[b] <= 16'h0000;
        bk_op_q[b] <= OP_NONE;
      end
    end
    else if (wr_cmd && !c_reject)
    begin
      bk_addr_q[c_bank] <= caddr_q;
      bk_data_q[c_bank] <= cdata_q;
      bk_op_q[c_bank] <= c_op;
    end
  end

  //--------------------------------------------------------------------
  // array update when a sequencer completes
  //--------------------------------------------------------------------
  // programming only clears bits, erase returns words to all ones
  always_ff @(posedge aclk)
  begin
    for (int b = 0; b < NB; b++)
    begin
      if (done[b])
      begin
        case (bk_op_q[b])
          OP_PROG: mem_q[b][bk_addr_q[b][IW:1]] <=
            mem_q[b][bk_addr_q[b][IW:1]] & bk_data_q[b];
          OP_SECT:
          begin
            for (int i = 0; i < SECTOR_WORDS; i++)
              mem_q[b][{bk_addr_q[b][IW:9], 8'h00} + IW'(i)] <=
                16'hffff;
          end
          OP_BULK:
          begin
            for (int i = 0; i < WORDS_P; i++)
              mem_q[b][i] <= 16'hffff;
          end
          default: ;
        endcase
      end
    end
  end

  //--------------------------------------------------------------------
  // axi read channels
  //--------------------------------------------------------------------
  wire [BW-1:0] ra = raddr_q[BW-1:0];
  wire [BW-1:0] ra_nx = BW'(ra + 1'b1);
  wire secured = nvm_security_setting_q[1:0] != SEC_OPEN;
  wire [15:0] arr_val = raddr_q[BW] ? {byte_at(ra), byte_at(ra_nx)}
                                    : {8'h00, byte_at(ra)};
  wire rd_map = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= REG_KEY1);
  logic [31:0] rd_val;

  // register read mux
  always_comb
  begin
    case (s_axi_araddr)
      REG_CLKDIV: rd_val = 32'(nvm_timing_clock_divider_q);
      REG_PROT: rd_val = 32'(nvm_region_protection_q);
      REG_SEC: rd_val = {23'h000000, secured, nvm_security_setting_q};
      REG_STAT: rd_val = {20'h00000, busy, stat_q};
      REG_MASK: rd_val = 32'(mask_q);
      REG_CDATA: rd_val = 32'(cdata_q);
      REG_CADDR: rd_val = 32'(caddr_q);
      REG_RADDR: rd_val = 32'(raddr_q);
      REG_RDATA: rd_val = secured ? 32'h00000000 : 32'(arr_val);
      default: rd_val = 32'h00000000;
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // one read in flight, data registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // level interrupt from unmasked sticky flags
  assign irq = |(stat_q & mask_q);
endmodule : bfcc_top

/* bench/bfcc_top_monitor.sv */
// bus-port assertion checker for the flash controller
`timescale 1ns/100ps
module bfcc_top_monitor
  import bfcc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write response
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  input wire logic irq
);
  // ----
  // helper state
  // ----
  logic [7:0] raddr_q;
  logic bad_a;
  // address of the read being answered
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      raddr_q <= s_axi_araddr;
  end
  // unmapped or unaligned read target
  assign bad_a = raddr_q > REG_KEY1 || raddr_q[1:0] != 2'h0;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----
  // assertions
  // ----
  property p_ar_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_answer: assert property (p_ar_answer)
    else $error("read not answered next cycle");
  property p_r_hold;
    s_axi_rvalid |=> $past(s_axi_rready) ? !s_axi_rvalid : (s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp));
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer not held or not released");
  property p_b_hold;
    s_axi_bvalid |=> $past(s_axi_bready) ? !s_axi_bvalid
      : (s_axi_bvalid && $stable(s_axi_bresp));
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response not held or not released");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while answer pending");
  property p_sec_bit;
    s_axi_rvalid && raddr_q == REG_SEC |-> s_axi_rdata[31:9] == 23'h0
      && s_axi_rdata[8] == (s_axi_rdata[1:0] != SEC_OPEN);
  endproperty
  a_sec_bit: assert property (p_sec_bit)
    else $error("secured flag disagrees with setting");
  property p_unmapped;
    s_axi_rvalid && bad_a |-> s_axi_rresp == RESP_SLVERR
      && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  property p_stat_bits;
    s_axi_rvalid && raddr_q == REG_STAT |-> s_axi_rdata[31:12] == 20'h0;
  endproperty
  a_stat_bits: assert property (p_stat_bits)
    else $error("status read has stray bits");
  property p_irq_reset;
    $rose(aresetn) |-> !irq;
  endproperty
  a_irq_reset: assert property (p_irq_reset)
    else $error("interrupt high out of reset");
endmodule : bfcc_top_monitor
bind bfcc_top bfcc_top_monitor bfcc_top_monitor_inst (.aclk(aclk),
  .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq));

/* bench/bfcc_cpu_model.sv */
// axi4-lite master model of the cpu side
`timescale 1ns/100ps
module bfcc_cpu_model
  import bfcc_pkg::*;
(
  // clock
  input wire logic aclk,
  // write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // idle bus at time zero
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // one register write, response accepted as soon as offered
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    r = bresp;
    bready <= 1'b0;
    // free edge before the next request
    @(posedge aclk);
  endtask : wr
  // one register read, data accepted as soon as offered
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // free edge before the next request
    @(posedge aclk);
  endtask : rd
endmodule : bfcc_cpu_model

/* bench/bfcc_top_tb.sv */
// self-checking bench for the banked flash command controller
`timescale 1ns/100ps
module bfcc_top_tb
  import bfcc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] ra [6] = '{32'h41000, 32'h01001, 32'h41001, 32'h41100,
    32'h51000, 32'h7fffe};
  logic [31:0] rv [6] = '{32'h1234, 32'h34, 32'h3456, 32'hffff,
    32'hffff, 32'hffff};
  // 125 MHz clock
  always #4 aclk = ~aclk;
  bfcc_top bfcc_top_inst (.aclk, .aresetn, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq);
  bfcc_cpu_model bfcc_cpu_model_inst (.aclk, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  // ----
  // shared tasks
  // ----
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    bfcc_cpu_model_inst.wr(a, d, 4'hf, r);
    chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : w
  task automatic rc(input string n, input logic [7:0] a,
    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    bfcc_cpu_model_inst.rd(a, d, r);
    chk(n, d, e);
  endtask : rc
  task automatic cmd(input logic [3:0] c, input logic [15:0] ad,
    input logic [15:0] d);
    w(REG_CDATA, {16'h0, d});
    w(REG_CADDR, {16'h0, ad});
    w(REG_CMD, {28'h0, c});
  endtask : cmd
  task automatic wait_done(input logic [3:0] m);
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 5000; i++)
    begin
      bfcc_cpu_model_inst.rd(REG_STAT, d, r);
      if ((d[3:0] & m) === m)
        break;
    end
  endtask : wait_done
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : do_reset
  // ----
  // scenarios
  // ----
  task automatic t_idle();
    logic [31:0] d;
    logic [1:0] r;
    w(REG_PROT, 32'h0);
    rc("div", REG_CLKDIV, 32'h0);
    rc("mask", REG_MASK, 32'h0);
    bfcc_cpu_model_inst.rd(8'h30, d, r);
    chk("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    bfcc_cpu_model_inst.wr(8'h31, 32'h0, 4'hf, r);
    chk("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    cmd({OP_PROG, 2'd2}, 16'h1000, 16'h0);
    rc("nodiv", REG_STAT, 32'h40);
    w(REG_STAT, 32'h40);
    rc("w1c", REG_STAT, 32'h0);
  endtask : t_idle
  task automatic t_erase();
    w(REG_CLKDIV, 32'h1);
    for (int b = 0; b < NB; b++)
      cmd({OP_SECT, 2'(b)}, b == 3 ? 16'hfe00 : 16'h1000, 16'h0);
    rc("busy", REG_STAT, 32'hf00);
    wait_done(4'hf);
    rc("done", REG_STAT, 32'h00f);
    w(REG_STAT, 32'hf);
    w(REG_PROT, 32'h1);
    cmd({OP_BULK, 2'd0}, 16'h0, 16'h0);
    rc("bulk", REG_STAT, 32'h10);
    w(REG_STAT, 32'h10);
  endtask : t_erase
  task automatic t_prog();
    logic [1:0] r;
    w(REG_PROT, 32'h0);
    w(REG_MASK, 32'h1);
    cmd({OP_PROG, 2'd0}, 16'h1000, 16'h1234);
    wait_done(4'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    w(REG_STAT, 32'h1);
    @(posedge aclk);
    chk("irqclr", {31'h0, irq}, 32'h0);
    w(REG_MASK, 32'h0);
    cmd({OP_PROG, 2'd0}, 16'h1002, 16'h5678);
    wait_done(4'h1);
    chk("irqmask", {31'h0, irq}, 32'h0);
    w(REG_STAT, 32'h1);
    cmd({OP_PROG, 2'd1}, 16'h1001, 16'h0);
    rc("odd", REG_STAT, 32'h20);
    w(REG_CADDR, 32'h0);
    bfcc_cpu_model_inst.wr(REG_CMD, 32'h6, 4'h3, r);
    rc("strb", REG_STAT, 32'h60);
    w(REG_PROT, 32'h9);
    cmd({OP_PROG, 2'd0}, 16'hfe00, 16'h0);
    cmd({OP_PROG, 2'd0}, 16'h07fe, 16'h0);
    rc("prot", REG_STAT, 32'h70);
    cmd({OP_PROG, 2'd0}, 16'h0800, 16'h0);
    wait_done(4'h1);
    rc("edge", REG_STAT, 32'h71);
    w(REG_STAT, 32'hff);
  endtask : t_prog
  task automatic t_sec();
    logic [15:0] v;
    w(REG_PROT, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      v = i < 4 ? 16'h0 : (i == 4 ? 16'h0009 : 16'hff00);
      cmd({OP_PROG, 2'd3}, 16'hfff0 + 16'(2 * i), v);
      wait_done(4'h8);
      w(REG_STAT, 32'h8);
    end
    do_reset();
    rc("protld", REG_PROT, 32'h9);
    rc("secld", REG_SEC, 32'h1ff);
    w(REG_RADDR, 32'h41000);
    rc("locked", REG_RDATA, 32'h0);
    w(REG_KEY0, 32'h1);
    w(REG_KEY1, 32'h0);
    rc("badkey", REG_SEC, 32'h1ff);
    w(REG_KEY0, 32'h0);
    w(REG_KEY1, 32'h0);
    rc("goodkey", REG_SEC, 32'h0fe);
    for (int i = 0; i < 6; i++)
    begin
      w(REG_RADDR, ra[i]);
      rc("array", REG_RDATA, rv[i]);
    end
  endtask : t_sec
  // main sequence
  initial
  begin
    do_reset();
    t_idle();
    t_erase();
    t_prog();
    t_sec();
    tally_and_finish();
  end
  // run time ceiling
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
endmodule : bfcc_top_tb
